// >>> cfg_lock_map.svh
// Offsets, key values and reset values of the configuration lock bank.
// Assumes word addressing on a simple synchronous request port.
`ifndef CFG_LOCK_MAP_SVH
`define CFG_LOCK_MAP_SVH

// ==========================================================
// Register indices (word address)
`define ADDR_W            4
`define IDX_KEY_FIRST     4'h0
`define IDX_KEY_SECOND    4'h1
`define IDX_LOCK_STATUS   4'h2
`define IDX_BANK_BASE     4'h8
`define BANK_WORDS        8
// Bank words at or above this index are read-only
`define BANK_RO_FIRST     6

// ==========================================================
// Key values, arbitrary for this design
`define KEY_FIRST_VAL     32'h5A5A_1234
`define KEY_SECOND_VAL    32'hA5A5_8765

// ==========================================================
// Reset values
`define BANK_RESET_VAL    32'h0000_0000
`define RO_WORD_VAL       32'h0000_0001

`endif

// >>> cfg_lock_pkg.sv
// Types of the configuration lock bank.
// Assumes nothing of its surroundings.
package cfg_lock_pkg;
  typedef enum logic [1:0] {
    LOCKED,
    HALF_KEYED,
    UNLOCKED
  } lock_state_t;
endpackage

// >>> cfg_bank_word.sv
// One writable word of the protected configuration bank.
// Assumes the caller has already gated the write with the lock state.
`timescale 1ns/1ps
`include "cfg_lock_map.svh"
module cfg_bank_word (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        we_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] q_o
);
  logic [31:0] val_r;
  logic [31:0] val_nxt;

  always_comb begin
    val_nxt = val_r;
    if (we_i) begin
      val_nxt = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      val_r <= `BANK_RESET_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign q_o = val_r;
endmodule

// >>> config_register_write_lock.sv
// What this block does
// - Lock engaged from reset; bank rejects writes but stays readable.
// - Unlock needs correct first-key write and correct second-key write.
// - Unlocked bank accepts writes to writable words; read-only words ignore.
// - One shared key pair and lock state for all cores.
// - Wrong key value written while unlocked re-engages the lock.
//
// Holds the key registers, lock state machine and protected bank.
// Limitation: a wrong key from any core relocks the bank for all cores.
// Assumes a single request port already arbitrated between all cores.
`timescale 1ns/1ps
`include "cfg_lock_map.svh"
module config_register_write_lock (
  input  wire logic                 ref_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 req_i,
  input  wire logic                 we_i,
  input  wire logic [`ADDR_W-1:0]   addr_i,
  input  wire logic [31:0]          wdata_i,
  output logic                      ack_o,
  output logic      [31:0]          rdata_o,
  output logic                      unlocked_o
);
  // ==========================================================
  // Request decode
  // Flags are decoded once so the lock and bank logic read plain names
  // Bank space is the upper half of the word index
  logic                      wr_req;
  logic                      rd_req;
  logic                      hit_key1;
  logic                      hit_key2;
  logic                      hit_status;
  logic                      hit_bank;
  logic                      wr_key1;
  logic                      wr_key2;
  logic                      key1_ok;
  logic                      key2_ok;

  always_comb begin
    wr_req     = req_i & we_i;
    rd_req     = req_i & ~we_i;
    hit_key1   = (addr_i == `IDX_KEY_FIRST);
    hit_key2   = (addr_i == `IDX_KEY_SECOND);
    hit_status = (addr_i == `IDX_LOCK_STATUS);
    hit_bank   = (addr_i >= `IDX_BANK_BASE);
    wr_key1    = wr_req & hit_key1;
    wr_key2    = wr_req & hit_key2;
  end

  // ==========================================================
  // Key compare
  // Exact match only; any other value counts as a wrong key
  always_comb begin
    key1_ok = (wdata_i == `KEY_FIRST_VAL);
    key2_ok = (wdata_i == `KEY_SECOND_VAL);
  end

  // ==========================================================
  // Lock state machine
  // One state for every core: a wrong key from any core locks them all
  cfg_lock_pkg::lock_state_t state_r;
  cfg_lock_pkg::lock_state_t state_nxt;

  // Single state for all cores, so one core's wrong key locks everyone
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cfg_lock_pkg::LOCKED: begin
        if (wr_key1 && key1_ok) begin
          state_nxt = cfg_lock_pkg::HALF_KEYED;
        end
      end
      cfg_lock_pkg::HALF_KEYED: begin
        if (wr_key2) begin
          state_nxt = key2_ok ? cfg_lock_pkg::UNLOCKED : cfg_lock_pkg::LOCKED;
        end else if (wr_key1 && !key1_ok) begin
          state_nxt = cfg_lock_pkg::LOCKED;
        end
      end
      cfg_lock_pkg::UNLOCKED: begin
        if ((wr_key1 && !key1_ok) || (wr_key2 && !key2_ok)) begin
          state_nxt = cfg_lock_pkg::LOCKED;
        end
      end
      default: begin
        state_nxt = cfg_lock_pkg::LOCKED;
      end
    endcase
  end

  // ==========================================================
  // State register
  // Power-on reset always lands in the locked state
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r <= cfg_lock_pkg::LOCKED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Protected bank
  logic [31:0]               bank_q [`BANK_WORDS];
  logic                      bank_sel;
  logic [2:0]                bank_idx;
  logic                      bank_open;
  logic [`BANK_WORDS-1:0]    bank_we;

  assign bank_sel = hit_bank;
  assign bank_idx = addr_i[2:0];

  // ==========================================================
  // Bank write gate
  // Writes while locked are dropped here, yet still acked below
  // Indices at or above the read-only boundary never get an enable
  always_comb begin
    bank_open = (state_r == cfg_lock_pkg::UNLOCKED);
    bank_we   = 8'h00;
    for (int k = 0; k < `BANK_RO_FIRST; k++) begin
      bank_we[k] = wr_req & bank_sel & bank_open & (bank_idx == 3'(k));
    end
  end

  // ==========================================================
  // Bank words
  // Read-only words have no storage, so no write can ever reach them
  genvar g;
  generate
    for (g = 0; g < `BANK_WORDS; g = g + 1) begin : gen_word
      if (g < `BANK_RO_FIRST) begin : gen_rw
        cfg_bank_word u_word (
          .ref_clk_i (ref_clk_i),
          .resetn_i  (resetn_i),
          .we_i      (bank_we[g]),
          .wdata_i   (wdata_i),
          .q_o       (bank_q[g])
        );
      end else begin : gen_ro
        assign bank_q[g] = `RO_WORD_VAL;
      end
    end
  endgenerate

  // ==========================================================
  // Status word
  // Shows the state before any key write of the same cycle takes effect
  // Bit 0 is the unlocked flag, bit 1 the half-keyed flag
  logic [31:0]               status_word;

  always_comb begin
    status_word    = 32'h0000_0000;
    status_word[0] = (state_r == cfg_lock_pkg::UNLOCKED);
    status_word[1] = (state_r == cfg_lock_pkg::HALF_KEYED);
  end

  // ==========================================================
  // Acknowledge
  // Every request is acked, dropped writes too, so no core ever stalls
  // Pulse lasts one cycle per request, back to back allowed
  logic                      ack_nxt;

  always_comb begin
    ack_nxt = req_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ack_o <= 1'h0;
    end else begin
      ack_o <= ack_nxt;
    end
  end

  // ==========================================================
  // Read data
  // Key words read as zero, so software cannot read the keys back
  logic [31:0]               rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_req) begin
      if (bank_sel) begin
        rdata_nxt = bank_q[bank_idx];
      end else if (hit_status) begin
        rdata_nxt = status_word;
      end else if (hit_key1 || hit_key2) begin
        rdata_nxt = 32'h0000_0000;
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // Lock flag
  // Taken from the next state, so it shows the key write of this edge
  // Reset clears it together with the state
  logic                      unl_nxt;

  always_comb begin
    unl_nxt = (state_nxt == cfg_lock_pkg::UNLOCKED);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      unlocked_o <= 1'h0;
    end else begin
      unlocked_o <= unl_nxt;
    end
  end
endmodule

// >>> cfg_lock_asserts.sv
// Concurrent checks on the ports of the configuration lock bank.
// Assumes it is bound into config_register_write_lock.
`timescale 1ns/1ps
`include "cfg_lock_map.svh"
module cfg_lock_asserts (
  input wire logic               ref_clk_i,
  input wire logic               resetn_i,
  input wire logic               req_i,
  input wire logic               we_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [31:0]        wdata_i,
  input wire logic               ack_o,
  input wire logic [31:0]        rdata_o,
  input wire logic               unlocked_o
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_ack_follow: assert property (req_i |=> ack_o) else $error("no ack");
  a_ack_only: assert property (!req_i |=> !ack_o) else $error("stray ack");
  a_locked_reset: assert property ($rose(resetn_i) |-> !unlocked_o) else $error("open");
  a_two_keys: assert property ($rose(unlocked_o) |-> $past(req_i && we_i && addr_i == 4'h1
    && wdata_i == `KEY_SECOND_VAL)) else $error("unlock without key");
  a_wrong_key: assert property (unlocked_o && req_i && we_i && ((addr_i == 4'h0
    && wdata_i != `KEY_FIRST_VAL) || (addr_i == 4'h1 && wdata_i != `KEY_SECOND_VAL))
    |=> !unlocked_o) else $error("lock kept");
  a_ro_word: assert property (req_i && !we_i && addr_i >= 4'hE |=> rdata_o == 32'h1)
    else $error("read-only word");
  a_one_state: assert property (req_i && !we_i && addr_i == 4'h2
    |=> rdata_o[0] == $past(unlocked_o)) else $error("status");
endmodule
bind config_register_write_lock cfg_lock_asserts u_chk (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .ack_o(ack_o), .rdata_o(rdata_o), .unlocked_o(unlocked_o));

// >>> tb.sv
// Self-checking bench for the configuration lock bank.
// Assumes one request port and a one-cycle ack.
`timescale 1ns/1ps
`include "cfg_lock_map.svh"
module tb;
  logic        ref_clk_i, resetn_i, req_i, we_i, ack_o, unlocked_o;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, bank[8];
  logic [32:0] q[$], e;
  logic [15:0] lf = 16'h6025;
  logic [1:0]  st = 2'h0;
  int          failures, cmp_count, cyc, i;
  config_register_write_lock uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .unlocked_o(unlocked_o));
  // ==========================================================
  // Tasks
  function automatic logic [31:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return {lf, ~lf};
  endfunction
  task automatic chk(input logic [32:0] s, input logic [32:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Model tracks state so expectations never come from the design
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    @(posedge ref_clk_i);
    req_i <= 1'h1; we_i <= w; addr_i <= a; wdata_i <= d;
    r = 32'h0;
    if (!w && a == 4'h2) r = {30'h0, st == 2'h1, st == 2'h2};
    if (!w && a >= 4'h8) r = (a >= 4'hE) ? 32'h1 : bank[a[2:0]];
    if (w && a == 4'h0) st = (d == `KEY_FIRST_VAL) ? ((st == 2'h2) ? st : 2'h1) : 2'h0;
    if (w && a == 4'h1) st = (d == `KEY_SECOND_VAL && st != 2'h0) ? 2'h2 : 2'h0;
    if (w && a >= 4'h8 && a < 4'hE && st == 2'h2) bank[a[2:0]] = d;
    q.push_back({st == 2'h2, r});
  endtask
  task automatic sweep(input string n);
    for (i = 2; i < 16; i++) acc(1'h1, i[3:0], rnd());
    for (i = 0; i < 16; i++) acc(1'h0, i[3:0], 32'h0);
    $display("test %s done", n);
  endtask
  task results();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Clock, monitor, timeout and sequence
  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      results();
    end
    if (ack_o === 1'h1 && q.size() > 0) begin
      e = q.pop_front();
      chk(rdata_o, e[31:0]);
      chk(unlocked_o, e[32]);
    end
  end
  initial begin
    resetn_i = 1'h0; req_i = 1'h0; we_i = 1'h0; addr_i = 4'h0; wdata_i = 32'h0;
    for (i = 0; i < 8; i++) bank[i] = `BANK_RESET_VAL;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    sweep("locked");
    acc(1'h1, 4'h1, `KEY_SECOND_VAL);
    acc(1'h1, 4'h0, `KEY_FIRST_VAL);
    acc(1'h0, 4'h2, 32'h0);
    acc(1'h1, 4'h0, `KEY_FIRST_VAL);
    acc(1'h1, 4'h1, `KEY_SECOND_VAL);
    sweep("unlocked");
    acc(1'h1, 4'h1, ~`KEY_SECOND_VAL);
    sweep("relocked");
    @(posedge ref_clk_i);
    req_i <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
    chk(q.size(), 33'h0);
    results();
  end
endmodule
